// [hdl/srqm_top.sv]
// shared ram pool and four typed queues behind one register port
`timescale 1ns/10ps
`include "srqm_consts.svh"

// How it works
// - 200 shared 16-bit registers, writable and readable by script and host alike.
// - pool is plain volatile storage reached through the same register port.
// - pool groups: float 46000, signed 46080, unsigned 46100, half 46180.
// - four independent queues, any element type mix, usable at once.
// - every typed port of one queue index reaches one shared queue memory.
// - bytes pushed through one typed port may be popped through another.
// - queue ports are buffers: writes append in order, reads remove oldest first.
// - reading more bytes than a queue holds returns an error, no data.
// - half ports at 47000 plus index, word ports at 47010 plus twice index.
// - queue capacity in bytes is set at 47900 before use, limited by memory.
// - read-only fill count at 47910 equals bytes written minus bytes read.
// - any write to 47930 flushes that queue and zeroes its fill count.
// - word elements take four bytes of queue space, half elements two.
module srqm_top
  import srqm_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rstn_i,
  // register access
  input  wire logic                 req_i,
  input  wire logic                 we_i,
  input  wire srqm_pkg::srqm_addr_t addr_i,
  input  wire logic [31:0]          wdata_i,
  // answer
  output logic                      ready_o,
  output logic                      ack_o,
  output logic                      err_o,
  output logic [31:0]               rdata_o
);

  import srqm_pkg::*;

  localparam int NQ = `SRQM_NUM_Q;
  localparam int CW = $clog2(`SRQM_FIFO_DEPTH + 1);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  srqm_state_t       state;
  srqm_state_t       next_state;
  srqm_op_t          op;
  logic [1:0]        dq;
  logic [1:0]        sq;
  logic [15:0]       wlo;
  logic [15:0]       rhi;
  logic [15:0]       pool_mem [`SRQM_POOL_WORDS];
  logic [5:0]        alloc [NQ];
  logic [5:0]        fill [NQ];
  logic [15:0]       head [NQ];
  logic [CW-1:0]     cnt [NQ];
  logic [NQ-1:0]     push_v;
  logic [NQ-1:0]     pop_r;
  logic [NQ-1:0]     flush;
  logic [NQ-1:0]     push_rdy;
  logic [NQ-1:0]     pop_vld;
  logic [15:0]       push_data;
  logic              take;
  logic              pool_we;
  logic              alloc_we;
  logic              next_ack;
  logic              next_err;
  logic [31:0]       next_rdata;
  logic [15:0]       pool_off;
  logic [7:0]        pool_idx;
  logic              pool_half;
  logic              pool_ok;
  logic [31:0]       pool_word;
  logic [5:0]        cq;
  logic              half_fits;
  logic              word_fits;

  assign take      = req_i && ready_o;
  assign pool_off  = addr_i - `SRQM_POOL_BASE;
  assign pool_idx  = pool_off[7:0];
  assign pool_half = (addr_i >= `SRQM_POOL_HALF);
  assign pool_ok   = pool_half || !pool_off[0];
  assign pool_word = {pool_mem[pool_idx], pool_mem[pool_idx + 8'h01]};
  assign cq        = fill[dq];
  assign half_fits = (cq + `SRQM_HALF_BYTES) <= alloc[dq];
  assign word_fits = (cq + `SRQM_WORD_BYTES) <= alloc[dq];

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  function automatic logic srqm_in_span(input srqm_addr_t a, input srqm_addr_t base,
                                        input srqm_addr_t span, input logic stride2);
    srqm_addr_t off;
    off = a - base;
    return (a >= base) && (off < span) && !(stride2 && off[0]);
  endfunction : srqm_in_span

  always_comb
  begin
    op = SRQM_OP_NONE;
    dq = 2'h0;
    if (addr_i >= `SRQM_POOL_BASE && addr_i < `SRQM_POOL_END)
    begin
      op = SRQM_OP_POOL;
    end
    else if (srqm_in_span(addr_i, `SRQM_Q_HALF, `SRQM_SPAN_HALF, 1'b0))
    begin
      op = SRQM_OP_QHALF;
      dq = 2'(addr_i - `SRQM_Q_HALF);
    end
    else if (srqm_in_span(addr_i, `SRQM_Q_WORD, `SRQM_SPAN_WORD, 1'b1))
    begin
      op = SRQM_OP_QWORD;
      dq = 2'((addr_i - `SRQM_Q_WORD) >> 1);
    end
    else if (srqm_in_span(addr_i, `SRQM_Q_INT, `SRQM_SPAN_WORD, 1'b1))
    begin
      op = SRQM_OP_QWORD;
      dq = 2'((addr_i - `SRQM_Q_INT) >> 1);
    end
    else if (srqm_in_span(addr_i, `SRQM_Q_FLT, `SRQM_SPAN_WORD, 1'b1))
    begin
      op = SRQM_OP_QWORD;
      dq = 2'((addr_i - `SRQM_Q_FLT) >> 1);
    end
    else if (srqm_in_span(addr_i, `SRQM_Q_ALLOC, `SRQM_SPAN_WORD, 1'b1))
    begin
      op = SRQM_OP_ALLOC;
      dq = 2'((addr_i - `SRQM_Q_ALLOC) >> 1);
    end
    else if (srqm_in_span(addr_i, `SRQM_Q_COUNT, `SRQM_SPAN_WORD, 1'b1))
    begin
      op = SRQM_OP_COUNT;
      dq = 2'((addr_i - `SRQM_Q_COUNT) >> 1);
    end
    else if (srqm_in_span(addr_i, `SRQM_Q_FLUSH, `SRQM_SPAN_WORD, 1'b1))
    begin
      op = SRQM_OP_FLUSH;
      dq = 2'((addr_i - `SRQM_Q_FLUSH) >> 1);
    end
  end

  // -----------------------------------------------------------------
  // request handling
  // -----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_ack   = 1'b0;
    next_err   = 1'b0;
    next_rdata = rdata_o;
    push_v     = '0;
    pop_r      = '0;
    flush      = '0;
    push_data  = wdata_i[15:0];
    pool_we    = 1'b0;
    alloc_we   = 1'b0;
    case (state)
      SRQM_IDLE:
      begin
        if (take)
        begin
          next_ack = 1'b1;
          case (op)
            SRQM_OP_POOL:
            begin
              if (!pool_ok)
                next_err = 1'b1;
              else if (we_i)
                pool_we = 1'b1;
              else
                next_rdata = pool_half ? {16'h0000, pool_mem[pool_idx]} : pool_word;
            end
            SRQM_OP_QHALF:
            begin
              if (we_i && !half_fits)
                next_err = 1'b1;
              else if (we_i)
                push_v[dq] = 1'b1;
              else if (cq < `SRQM_HALF_BYTES)
                next_err = 1'b1;
              else
              begin
                pop_r[dq]  = 1'b1;
                next_rdata = {16'h0000, head[dq]};
              end
            end
            SRQM_OP_QWORD:
            begin
              if (we_i && !word_fits)
                next_err = 1'b1;
              else if (we_i)
              begin
                push_v[dq] = 1'b1;
                push_data  = wdata_i[31:16];
                next_ack   = 1'b0;
                next_state = SRQM_PUSH_LO;
              end
              else if (cq < `SRQM_WORD_BYTES)
                next_err = 1'b1;
              else
              begin
                pop_r[dq]  = 1'b1;
                next_ack   = 1'b0;
                next_state = SRQM_POP_LO;
              end
            end
            SRQM_OP_ALLOC:
            begin
              if (!we_i)
                next_rdata = {26'h0, alloc[dq]};
              else if (wdata_i > {26'h0, `SRQM_Q_MAX_BYTES})
                next_err = 1'b1;
              else
                alloc_we = 1'b1;
            end
            SRQM_OP_COUNT:
            begin
              if (we_i)
                next_err = 1'b1;
              else
                next_rdata = {26'h0, cq};
            end
            SRQM_OP_FLUSH:
            begin
              if (we_i)
                flush[dq] = 1'b1;
              else
                next_err = 1'b1;
            end
            default:
            begin
              next_err = 1'b1;
            end
          endcase
        end
      end
      SRQM_PUSH_LO:
      begin
        push_v[sq] = 1'b1;
        push_data  = wlo;
        next_ack   = 1'b1;
        next_state = SRQM_IDLE;
      end
      SRQM_POP_LO:
      begin
        pop_r[sq]  = 1'b1;
        next_rdata = {rhi, head[sq]};
        next_ack   = 1'b1;
        next_state = SRQM_IDLE;
      end
      default:
      begin
        next_state = SRQM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      state   <= SRQM_IDLE;
      ready_o <= 1'b1;
    end
    else
    begin
      state   <= next_state;
      ready_o <= (next_state == SRQM_IDLE);
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      sq  <= 2'h0;
      wlo <= 16'h0000;
      rhi <= 16'h0000;
    end
    else if (take)
    begin
      sq  <= dq;
      wlo <= wdata_i[15:0];
      rhi <= head[dq];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o   <= next_ack;
      err_o   <= next_err;
      rdata_o <= next_rdata;
    end
  end

  // -----------------------------------------------------------------
  // shared pool and capacities
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (pool_we)
    begin
      if (pool_half)
        pool_mem[pool_idx] <= wdata_i[15:0];
      else
      begin
        pool_mem[pool_idx]         <= wdata_i[31:16];
        pool_mem[pool_idx + 8'h01] <= wdata_i[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      alloc <= '{default: 6'h00};
    else if (alloc_we)
      alloc[dq] <= wdata_i[5:0];
  end

  // -----------------------------------------------------------------
  // one half-wide fifo per queue
  // -----------------------------------------------------------------
  for (genvar q = 0; q < NQ; q++)
  begin : g_queue
    srqm_fifo #(
      .WIDTH (`SRQM_FIFO_WIDTH),
      .DEPTH (`SRQM_FIFO_DEPTH)
    ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .rstn_i      (rstn_i),
      .flush_i     (flush[q]),
      .in_valid_i  (push_v[q]),
      .in_ready_o  (push_rdy[q]),
      .in_data_i   (push_data),
      .out_valid_o (pop_vld[q]),
      .out_ready_i (pop_r[q]),
      .out_data_o  (head[q]),
      .count_o     (cnt[q])
    );
    assign fill[q] = {cnt[q], 1'b0};

    property p_flush;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      take && we_i && op == SRQM_OP_FLUSH && dq == q |=> fill[q] == 6'h00;
    endproperty
    a_flush: assert property (p_flush) else $error("flush left data");

    property p_half_push;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      take && we_i && op == SRQM_OP_QHALF && dq == q && half_fits
        |=> fill[q] == $past(fill[q]) + `SRQM_HALF_BYTES;
    endproperty
    a_half_push: assert property (p_half_push) else $error("half push count wrong");

    property p_word_push;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      take && we_i && op == SRQM_OP_QWORD && dq == q && word_fits
        |=> ##1 fill[q] == $past(fill[q], 2) + `SRQM_WORD_BYTES;
    endproperty
    a_word_push: assert property (p_word_push) else $error("word push count wrong");

    property p_room;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      push_v[q] |-> push_rdy[q] && fill[q] < alloc[q] + 6'h01;
    endproperty
    a_room: assert property (p_room) else $error("push beyond capacity");

    property p_pop_avail;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      pop_r[q] |-> pop_vld[q];
    endproperty
    a_pop_avail: assert property (p_pop_avail) else $error("pop from empty queue");
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_word_write;
    take && we_i && op == SRQM_OP_QWORD && word_fits;
  endsequence

  sequence s_word_read;
    take && !we_i && op == SRQM_OP_QWORD && cq >= `SRQM_WORD_BYTES;
  endsequence

  property p_word_write_seq;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_word_write |=> !ack_o && !ready_o ##1 ack_o && !err_o && ready_o;
  endproperty
  a_word_write_seq: assert property (p_word_write_seq) else $error("word write steps");

  property p_word_read_seq;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_word_read |=> state == SRQM_POP_LO ##1 ack_o && !err_o;
  endproperty
  a_word_read_seq: assert property (p_word_read_seq) else $error("word read steps");

  property p_underrun;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    take && !we_i && op == SRQM_OP_QHALF && cq < `SRQM_HALF_BYTES
      |-> pop_r == '0 ##1 ack_o && err_o;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");

  property p_overrun;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    take && we_i && op == SRQM_OP_QWORD && !word_fits
      |-> push_v == '0 ##1 ack_o && err_o && ready_o;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not refused");

  property p_count_read;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    take && !we_i && op == SRQM_OP_COUNT |=> ack_o && rdata_o == {26'h0, $past(cq)};
  endproperty
  a_count_read: assert property (p_count_read) else $error("fill count read wrong");

  property p_unmapped;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    take && op == SRQM_OP_NONE |=> ack_o && err_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");

  property p_pool_half;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    take && we_i && op == SRQM_OP_POOL && pool_half
      |=> pool_mem[$past(pool_idx)] == $past(wdata_i[15:0]) && !err_o;
  endproperty
  a_pool_half: assert property (p_pool_half) else $error("pool write lost");

  property p_pool_word;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    take && !we_i && op == SRQM_OP_POOL && !pool_half && pool_ok
      |=> rdata_o == $past(pool_word);
  endproperty
  a_pool_word: assert property (p_pool_word) else $error("pool word read wrong");

  property p_alloc;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    take && we_i && op == SRQM_OP_ALLOC && wdata_i <= {26'h0, `SRQM_Q_MAX_BYTES}
      |=> alloc[$past(dq)] == $past(wdata_i[5:0]) && !err_o;
  endproperty
  a_alloc: assert property (p_alloc) else $error("capacity not stored");

endmodule : srqm_top

// [hdl/srqm_consts.svh]
// address map, sizes and counts of the shared ram and queue mailbox
`ifndef SRQM_CONSTS_SVH
`define SRQM_CONSTS_SVH

// -----------------------------------------------------------------
// shared pool, one address per 16-bit half
// -----------------------------------------------------------------
`define SRQM_POOL_BASE    16'hB3B0
`define SRQM_POOL_INT     16'hB400
`define SRQM_POOL_UNS     16'hB414
`define SRQM_POOL_HALF    16'hB464
`define SRQM_POOL_END     16'hB478
`define SRQM_POOL_WORDS   200

// -----------------------------------------------------------------
// queue ports and per-queue control
// -----------------------------------------------------------------
`define SRQM_Q_HALF       16'hB798
`define SRQM_Q_WORD       16'hB7A2
`define SRQM_Q_INT        16'hB7AC
`define SRQM_Q_FLT        16'hB7B6
`define SRQM_Q_ALLOC      16'hBB1C
`define SRQM_Q_COUNT      16'hBB26
`define SRQM_Q_FLUSH      16'hBB3A
`define SRQM_SPAN_HALF    16'h0004
`define SRQM_SPAN_WORD    16'h0008

// -----------------------------------------------------------------
// queue sizing
// -----------------------------------------------------------------
`define SRQM_NUM_Q        4
`define SRQM_FIFO_WIDTH   16
`define SRQM_FIFO_DEPTH   16
`define SRQM_HALF_BYTES   6'h02
`define SRQM_WORD_BYTES   6'h04
`define SRQM_Q_MAX_BYTES  6'h20

`endif

// [hdl/srqm_pkg.sv]
// types shared by the mailbox files
package srqm_pkg;

  typedef logic [15:0] srqm_addr_t;

  typedef enum logic [1:0] {
    SRQM_IDLE,
    SRQM_PUSH_LO,
    SRQM_POP_LO
  } srqm_state_t;

  typedef enum logic [2:0] {
    SRQM_OP_NONE,
    SRQM_OP_POOL,
    SRQM_OP_QHALF,
    SRQM_OP_QWORD,
    SRQM_OP_ALLOC,
    SRQM_OP_COUNT,
    SRQM_OP_FLUSH
  } srqm_op_t;

endpackage : srqm_pkg

// [hdl/srqm_fifo.sv]
// first-word-fall-through fifo holding the halves of one queue
`timescale 1ns/10ps
module srqm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rstn_i,
  // control
  input  wire logic                       flush_i,
  // fill side
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  // drain side
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [WIDTH-1:0]                out_data_o,
  // level
  output logic [$clog2(DEPTH+1)-1:0]      count_o
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign in_ready_o  = (count_o != CW'(DEPTH));
  assign out_valid_o = (count_o != '0);
  assign out_data_o  = mem[rd_ptr];
  assign do_wr       = in_valid_i && in_ready_o;
  assign do_rd       = out_ready_i && out_valid_o;

  always_ff @(posedge ref_clk_i)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i || flush_i)
    begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count_o <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + PW'(1);
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + PW'(1);
      end
      if (do_wr && !do_rd)
      begin
        count_o <= count_o + CW'(1);
      end
      else if (do_rd && !do_wr)
      begin
        count_o <= count_o - CW'(1);
      end
    end
  end

endmodule : srqm_fifo

// [test/srqm_host_model.sv]
// host-side model that drives the mailbox register port
`timescale 1ns/10ps
`include "srqm_consts.svh"
module srqm_host_model
  import srqm_pkg::*;
(
  // clock
  input  wire logic                 ref_clk_i,
  // answer from the block
  input  wire logic                 ready_i,
  input  wire logic                 ack_i,
  input  wire logic                 err_i,
  input  wire logic [31:0]          rdata_i,
  // request to the block
  output logic                      req_o,
  output logic                      we_o,
  output srqm_pkg::srqm_addr_t      addr_o,
  output logic [31:0]               wdata_o
);
  import srqm_pkg::*;

  initial
  begin
    req_o   = 1'b0;
    we_o    = 1'b0;
    addr_o  = 16'h0000;
    wdata_o = 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // one access: hold until taken, then wait for the answer
  // ---------------------------------------------------------------
  task automatic access(input logic we, input srqm_addr_t addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
    int n;
    @(negedge ref_clk_i);
    req_o   = 1'b1;
    we_o    = we;
    addr_o  = addr;
    wdata_o = wdata;
    n = 0;
    while (ready_i !== 1'b1 && n < 8)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    @(negedge ref_clk_i);
    // released lines show the inverse, never the stale value
    req_o   = 1'b0;
    we_o    = ~we_o;
    addr_o  = ~addr_o;
    wdata_o = ~wdata_o;
    n = 0;
    while (ack_i !== 1'b1 && n < 8)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    rdata = rdata_i;
    err   = (n < 8) ? err_i : 1'bx;
  endtask : access

  // capacity is set before a queue is used, except queue zero, which first takes one refused half write
  task automatic setup_queue(input logic [1:0] q, input logic [31:0] bytes, output logic err);
    logic [31:0] r;
    access(1'b1, `SRQM_Q_ALLOC + {13'h0000, q, 1'b0}, bytes, r, err);
  endtask : setup_queue
endmodule : srqm_host_model

// [test/srqm_top_tb.sv]
// self-checking bench for the shared ram and queue mailbox
`timescale 1ns/10ps
`include "srqm_consts.svh"
module srqm_top_tb;
  import srqm_pkg::*;

  logic        ref_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        req_i;
  logic        we_i;
  srqm_addr_t  addr_i;
  logic [31:0] wdata_i;
  logic        ready_o;
  logic        ack_o;
  logic        err_o;
  logic [31:0] rdata_o;
  int          errors      = 0;
  int          comparisons = 0;
  logic        g;

  localparam srqm_addr_t  PA[5] = '{`SRQM_POOL_BASE, `SRQM_POOL_INT, `SRQM_POOL_UNS + 16'h004E,
                                    `SRQM_POOL_HALF, `SRQM_POOL_HALF + 16'h0013};
  localparam logic [31:0] PD[5] = '{32'h3F80_0000, 32'hFFFF_FFFE, 32'h1234_5678,
                                    32'h0000_ABCD, 32'hFFFF_1357};
  localparam logic [31:0] PX[5] = '{32'h3F80_0000, 32'hFFFF_FFFE, 32'h1234_5678,
                                    32'h0000_ABCD, 32'h0000_1357};

  always #12.5 ref_clk_i = ~ref_clk_i;

  srqm_top u_srqm_top (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .req_i     (req_i),
    .we_i      (we_i),
    .addr_i    (addr_i),
    .wdata_i   (wdata_i),
    .ready_o   (ready_o),
    .ack_o     (ack_o),
    .err_o     (err_o),
    .rdata_o   (rdata_o)
  );

  srqm_host_model u_srqm_host_model (
    .ref_clk_i (ref_clk_i),
    .ready_i   (ready_o),
    .ack_i     (ack_o),
    .err_i     (err_o),
    .rdata_i   (rdata_o),
    .req_o     (req_i),
    .we_o      (we_i),
    .addr_o    (addr_i),
    .wdata_o   (wdata_i)
  );

  // ---------------------------------------------------------------
  // compare, access and closing tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input srqm_addr_t a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic        f;
    u_srqm_host_model.access(1'b1, a, d, r, f);
    check($sformatf("write error flag at %0d", a), {31'h0, f}, {31'h0, e});
  endtask : wr

  task automatic rd(input srqm_addr_t a, input logic [31:0] x, input logic e);
    logic [31:0] r;
    logic        f;
    u_srqm_host_model.access(1'b0, a, 32'h0000_0000, r, f);
    check($sformatf("read error flag at %0d", a), {31'h0, f}, {31'h0, e});
    if (e == 1'b0)
      check($sformatf("read data at %0d", a), r, x);
  endtask : rd

  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial
  begin
    #(25 * 4000);
    errors++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    check("ready after reset", {31'h0, ready_o}, 32'h0000_0001);
    check("ack after reset", {31'h0, ack_o}, 32'h0000_0000);
    check("read data after reset", rdata_o, 32'h0000_0000);
    // pool groups do not overlap
    for (int i = 0; i < 5; i++) wr(PA[i], PD[i], 1'b0);
    for (int i = 0; i < 5; i++) rd(PA[i], PX[i], 1'b0);
    rd(`SRQM_POOL_BASE + 16'h0001, 32'h0, 1'b1);
    rd(`SRQM_POOL_END, 32'h0, 1'b1);
    // queue zero: capacity, mixed views, overrun and underrun
    wr(`SRQM_Q_HALF, 32'h0000_1111, 1'b1);
    wr(`SRQM_Q_ALLOC, 32'h0000_0021, 1'b1);
    wr(`SRQM_Q_ALLOC, 32'h0000_0008, 1'b0);
    rd(`SRQM_Q_ALLOC, 32'h0000_0008, 1'b0);
    wr(`SRQM_Q_WORD, 32'hAAAA_BBBB, 1'b0);
    rd(`SRQM_Q_COUNT, 32'h0000_0004, 1'b0);
    wr(`SRQM_Q_HALF, 32'h0000_1234, 1'b0);
    wr(`SRQM_Q_HALF, 32'h0000_5678, 1'b0);
    wr(`SRQM_Q_HALF, 32'h0000_9999, 1'b1);
    rd(`SRQM_Q_COUNT, 32'h0000_0008, 1'b0);
    rd(`SRQM_Q_HALF, 32'h0000_AAAA, 1'b0);
    rd(`SRQM_Q_FLT, 32'hBBBB_1234, 1'b0);
    rd(`SRQM_Q_COUNT, 32'h0000_0002, 1'b0);
    rd(`SRQM_Q_WORD, 32'h0, 1'b1);
    rd(`SRQM_Q_COUNT, 32'h0000_0002, 1'b0);
    rd(`SRQM_Q_HALF, 32'h0000_5678, 1'b0);
    rd(`SRQM_Q_HALF, 32'h0, 1'b1);
    rd(`SRQM_Q_WORD + 16'h0001, 32'h0, 1'b1);
    // queue one filled through the signed view, half drained through unsigned, then flushed
    u_srqm_host_model.setup_queue(2'h1, 32'h0000_0020, g);
    check("capacity set on queue one", {31'h0, g}, 32'h0000_0000);
    for (int i = 0; i < 8; i++) wr(`SRQM_Q_INT + 16'h0002, 32'hC0DE_0000 + i, 1'b0);
    wr(`SRQM_Q_INT + 16'h0002, 32'hDEAD_0000, 1'b1);
    rd(`SRQM_Q_COUNT + 16'h0002, 32'h0000_0020, 1'b0);
    for (int i = 0; i < 4; i++) rd(`SRQM_Q_WORD + 16'h0002, 32'hC0DE_0000 + i, 1'b0);
    rd(`SRQM_Q_COUNT, 32'h0000_0000, 1'b0);
    wr(`SRQM_Q_FLUSH + 16'h0002, 32'h0000_0055, 1'b0);
    rd(`SRQM_Q_COUNT + 16'h0002, 32'h0000_0000, 1'b0);
    rd(`SRQM_Q_HALF + 16'h0001, 32'h0, 1'b1);
    rd(`SRQM_Q_FLUSH + 16'h0002, 32'h0, 1'b1);
    wr(`SRQM_Q_COUNT + 16'h0002, 32'h0000_0001, 1'b1);
    // all four queues at once, each keeps its own data
    for (int q = 0; q < 4; q++)
    begin
      u_srqm_host_model.setup_queue(2'(q), 32'h0000_0004, g);
      check("capacity set", {31'h0, g}, 32'h0000_0000);
      wr(`SRQM_Q_HALF + 16'(q), 32'h0000_00A0 + q, 1'b0);
    end
    for (int q = 0; q < 4; q++)
    begin
      rd(`SRQM_Q_COUNT + 16'(2 * q), 32'h0000_0002, 1'b0);
      rd(`SRQM_Q_HALF + 16'(q), 32'h0000_00A0 + q, 1'b0);
    end
    // host fills queue zero, script drains it and answers in queue one
    wr(`SRQM_Q_WORD, 32'h0102_0304, 1'b0);
    rd(`SRQM_Q_HALF, 32'h0000_0102, 1'b0);
    rd(`SRQM_Q_HALF, 32'h0000_0304, 1'b0);
    wr(`SRQM_Q_FLT + 16'h0002, 32'h4049_0FDB, 1'b0);
    rd(`SRQM_Q_WORD + 16'h0002, 32'h4049_0FDB, 1'b0);
    finish_test();
  end
endmodule : srqm_top_tb
